// File: bench/line_side_model.sv
// line-side and datapath model feeding the channel status inputs
`timescale 1ns/100ps
module line_side_model (
  // wanted status: int id, line status, levels, modem pins, serial
  input  wire logic [31:0] i_stat,
  // status towards the channel
  output logic [31:0]      o_stat
);
  // passed straight on: the bench moves it just after an edge, and a
  // register here would show unknowns at the first reset edge
  // holds steady, idle high serial included, until told otherwise
  always_comb
  begin
    o_stat = i_stat;
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench for the channel register bank
`timescale 1ns/100ps
`include "chan_regs_cfg.svh"
module tb_top;
  logic                 I_CLOCK;
  logic                 I_RESET_N;
  logic                 I_POWERUP_N;
  logic                 I_WR;
  logic                 I_RD;
  logic [4:0]           I_SEL;
  chan_regs_pkg::byte_t I_WDATA;
  chan_regs_pkg::byte_t O_RDATA;
  logic                 O_TX;
  logic                 O_OP2_N;
  logic                 O_RTS_N;
  logic                 O_DTR_N;
  logic                 O_RECEIVE_READY_N_N;
  logic                 O_TRANSMIT_READY_N_N;
  logic                 O_INT;
  logic                 O_INT_OE;
  logic [31:0]          stat;
  logic [31:0]          line;
  logic [31:0]          seed;
  logic [31:0]          nx;
  logic [7:0]           pins;
  logic [7:0]           pe;
  int                   fail_count;
  int                   compares;
  int                   cycles;
  int                   i;
  chan_regs_pkg::byte_t rst_tab [20] = '{8'h00, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h60, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  assign pins = {O_TX, O_OP2_N, O_RTS_N, O_DTR_N,
                 O_RECEIVE_READY_N_N, O_TRANSMIT_READY_N_N, O_INT, O_INT_OE};

  chan_regs chan_regs_inst (
    .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_POWERUP_N(I_POWERUP_N),
    .I_WR(I_WR), .I_RD(I_RD), .I_SEL(I_SEL), .I_WDATA(I_WDATA),
    .O_RDATA(O_RDATA), .I_INT_ID(line[3:0]), .I_LINE_STAT(line[11:4]),
    .I_RX_LEVEL(line[18:12]), .I_TX_LEVEL(line[25:19]),
    .I_TX_SERIAL(line[30]), .I_CTS_N(line[26]), .I_DSR_N(line[27]),
    .I_RI_N(line[28]), .I_CD_N(line[29]), .O_TX(O_TX),
    .O_OP2_N(O_OP2_N), .O_RTS_N(O_RTS_N), .O_DTR_N(O_DTR_N),
    .O_RECEIVE_READY_N_N(O_RECEIVE_READY_N_N), .O_TRANSMIT_READY_N_N(O_TRANSMIT_READY_N_N), .O_INT(O_INT),
    .O_INT_OE(O_INT_OE));

  line_side_model line_side_model_inst (
    .i_stat(stat), .o_stat(line));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // fifo levels kept within 0..64, the only counts a fifo can show
  function automatic logic [31:0] mk_stat(input logic [31:0] r);
    logic [31:0] s;
    s = r;
    s[18:12] = r[18:12] % 7'h41;
    s[25:19] = r[25:19] % 7'h41;
    return s;
  endfunction

  // pins with mcr and lcr at zero
  function automatic logic [7:0] pin_exp(input logic [31:0] s);
    return {s[30], 3'b111, s[18:12] == 7'h00, s[25:19] == `FIFO_DEPTH,
            ~s[0], 1'b0};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] s, input logic [7:0] v);
    @(posedge I_CLOCK);
    I_WR    <= 1'b1;
    I_SEL   <= s;
    I_WDATA <= v;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] s, input logic [7:0] exp);
    @(posedge I_CLOCK);
    I_RD  <= 1'b1;
    I_SEL <= s;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    @(negedge I_CLOCK);
    chk(O_RDATA, exp);
  endtask

  task automatic pulse(input logic pw);
    @(posedge I_CLOCK);
    if (pw)
      I_POWERUP_N <= 1'b0;
    else
      I_RESET_N <= 1'b0;
    repeat (2) @(posedge I_CLOCK);
    I_POWERUP_N <= 1'b1;
    I_RESET_N   <= 1'b1;
  endtask

  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    I_CLOCK = 1'b0;
    forever #50 I_CLOCK = ~I_CLOCK;
  end

  // run needs well under a thousand cycles
  always @(posedge I_CLOCK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    I_RESET_N   = 1'b0;
    I_POWERUP_N = 1'b0;
    I_WR        = 1'b0;
    I_RD        = 1'b0;
    I_SEL       = 5'h00;
    I_WDATA     = 8'h00;
    stat        = 32'h7C00_0601;
    seed        = 32'h844AC906;
    nx          = 32'h0000_0000;
    fail_count  = 0;
    compares    = 0;
    cycles      = 0;
    repeat (9) @(posedge I_CLOCK);
    @(negedge I_CLOCK);
    chk(pins, 8'hF8);
    @(posedge I_CLOCK);
    I_RESET_N   <= 1'b1;
    I_POWERUP_N <= 1'b1;
    for (i = 0; i < 20; i++)
      rd(5'(i), rst_tab[i]);
    for (i = 12; i < 16; i++)
    begin
      seed = xs(seed);
      wr(5'(i), seed[7:0]);
      rd(5'(i), seed[7:0]);
    end
    wr(`SEL_IER, 8'hFF);
    rd(`SEL_IER, 8'h0F);
    wr(`SEL_DIV_FRAC, 8'hA5);
    rd(`SEL_DIV_FRAC, 8'h00);
    wr(`SEL_EFR, 8'h10);
    wr(`SEL_IER, 8'hFF);
    rd(`SEL_IER, 8'hFF);
    wr(`SEL_DIV_FRAC, 8'hA5);
    seed = xs(seed);
    wr(`SEL_DIV_LOW, seed[7:0]);
    wr(`SEL_DIV_HIGH, seed[15:8]);
    wr(`SEL_SPR, 8'h5A);
    wr(`SEL_PAUSE_TWO, seed[23:16]);
    pulse(1'b0);
    rd(`SEL_DIV_LOW, seed[7:0]);
    rd(`SEL_DIV_HIGH, seed[15:8]);
    rd(`SEL_SPR, 8'hFF);
    rd(`SEL_PAUSE_TWO, 8'h00);
    rd(`SEL_IER, 8'h00);
    rd(`SEL_DIV_FRAC, 8'h00);
    pulse(1'b1);
    rd(`SEL_DIV_LOW, 8'h01);
    rd(`SEL_DIV_HIGH, 8'h00);
    // modem changes left pending must not survive reset
    @(posedge I_CLOCK);
    stat[29:26] <= 4'h5;
    repeat (3) @(posedge I_CLOCK);
    pulse(1'b0);
    rd(`SEL_MSR, 8'hA0);
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      nx = mk_stat(seed);
      if (i == 0)
        nx[25:12] = {`FIFO_DEPTH, 7'h00};
      @(posedge I_CLOCK);
      stat <= nx;
      repeat (3) @(posedge I_CLOCK);
      @(negedge I_CLOCK);
      chk(pins, pin_exp(nx));
      wr(`SEL_FCTR, 8'h40);
      rd(`SEL_SPR, {1'b0, nx[18:12]});
      wr(`SEL_SPR, 8'h81);
      // enhanced_mode_select cannot be read back; its count select shows the write
      rd(`SEL_FIFO_LEVEL_COUNT, {1'b0, nx[25:19]});
      rd(`SEL_SPR, {1'b0, nx[25:19]});
      wr(`SEL_SPR, 8'h80);
      wr(`SEL_FCTR, 8'h00);
      rd(`SEL_SPR, 8'hFF);
    end
    // tx, op2, rts, dtr and int enable pins leave their reset levels once lcr and mcr are programmed
    pe = pin_exp(nx);
    wr(`SEL_LCR, 8'h40);
    wr(`SEL_MCR, 8'h0B);
    wr(`SEL_ISR_FCR, 8'h01);
    rd(`SEL_ISR_FCR, {4'hC, nx[3:0]});
    rd(`SEL_LSR, nx[11:4]);
    repeat (2) @(posedge I_CLOCK);
    @(negedge I_CLOCK);
    chk(pins, {4'h0, pe[3:1], 1'b1});
    give_verdict();
  end
endmodule

// File: common/cfg_byte_if.sv
// load path and stored value of one 8-bit configuration byte
`timescale 1ns/100ps
interface cfg_byte_if;
  logic                 load;
  chan_regs_pkg::byte_t value_in;
  chan_regs_pkg::byte_t value_out;
  modport ctrl (output load, output value_in, input value_out);
  modport store (input load, input value_in, output value_out);
endinterface

// File: common/chan_regs_cfg.svh
// constants for the channel register bank: selects, reset values, fields
`ifndef CHAN_REGS_CFG_SVH
`define CHAN_REGS_CFG_SVH

// register select codes on the access port
`define SEL_RX_TX        5'h00
`define SEL_IER          5'h01
`define SEL_ISR_FCR      5'h02
`define SEL_LCR          5'h03
`define SEL_MCR          5'h04
`define SEL_LSR          5'h05
`define SEL_MSR          5'h06
`define SEL_SPR          5'h07
`define SEL_DIV_LOW      5'h08
`define SEL_DIV_HIGH     5'h09
`define SEL_DIV_FRAC     5'h0A
`define SEL_EFR          5'h0B
`define SEL_RESUME_ONE   5'h0C
`define SEL_RESUME_TWO   5'h0D
`define SEL_PAUSE_ONE    5'h0E
`define SEL_PAUSE_TWO    5'h0F
`define SEL_FCTR         5'h10
`define SEL_ENHANCED_MODE_SELECT         5'h11
`define SEL_FIFO_LEVEL_COUNT         5'h12
`define SEL_TRIG_COUNT   5'h13

// reset values
`define RST_DIV_LOW      8'h01
`define RST_DIV_HIGH     8'h00
`define RST_ZERO         8'h00
`define RST_ISR          8'h01
`define RST_LSR          8'h60
`define RST_SPR          8'hFF
`define RST_ENHANCED_MODE_SELECT         8'h80

// field positions
`define EFR_ENH_BIT      4
`define FCTR_SWAP_BIT    6
`define ENHANCED_MODE_SELECT_CNT_TX_BIT  0
`define LCR_BREAK_BIT    6
`define MCR_DTR_BIT      0
`define MCR_RTS_BIT      1
`define MCR_OP2_BIT      3

// fifo depth in characters
`define FIFO_DEPTH       7'h40

`endif

// File: common/chan_regs_pkg.sv
// types shared by the channel register bank
package chan_regs_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] level_t;
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_t;
endpackage

// File: rtl/cfg_byte_reg.sv
// one read/write byte register with a parameterised reset value
`timescale 1ns/100ps
module cfg_byte_reg #(
  parameter chan_regs_pkg::byte_t RESET_VAL = 8'h00
) (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  // load port
  cfg_byte_if.store   bus
);
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      bus.value_out <= RESET_VAL;
    else if (bus.load)
      bus.value_out <= bus.value_in;
  end
endmodule

// File: rtl/chan_regs.sv
// reset state and register bank of one uart channel
`timescale 1ns/100ps
`include "chan_regs_cfg.svh"
module chan_regs (
  // clock and resets
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RESET_N,
  input  wire logic                  I_POWERUP_N,
  // register access
  input  wire logic                  I_WR,
  input  wire logic                  I_RD,
  input  wire logic [4:0]            I_SEL,
  input  wire chan_regs_pkg::byte_t  I_WDATA,
  output chan_regs_pkg::byte_t       O_RDATA,
  // channel datapath status
  input  wire logic [3:0]            I_INT_ID,
  input  wire chan_regs_pkg::byte_t  I_LINE_STAT,
  input  wire chan_regs_pkg::level_t I_RX_LEVEL,
  input  wire chan_regs_pkg::level_t I_TX_LEVEL,
  input  wire logic                  I_TX_SERIAL,
  // modem inputs, active low
  input  wire logic                  I_CTS_N,
  input  wire logic                  I_DSR_N,
  input  wire logic                  I_RI_N,
  input  wire logic                  I_CD_N,
  // pins
  output logic                       O_TX,
  output logic                       O_OP2_N,
  output logic                       O_RTS_N,
  output logic                       O_DTR_N,
  output logic                       O_RECEIVE_READY_N_N,
  output logic                       O_TRANSMIT_READY_N_N,
  output logic                       O_INT,
  output logic                       O_INT_OE
);
  chan_regs_pkg::byte_t   div_low_r, div_high_r, div_frac_r;
  chan_regs_pkg::byte_t   ier_r, fcr_r, lcr_r, mcr_r, efr_r, fctr_r;
  chan_regs_pkg::byte_t   trig_count_r, isr_r, lsr_r, msr_r;
  chan_regs_pkg::byte_t   rd_nxt;
  chan_regs_pkg::modem_t  modem_now, modem_prev_r;
  chan_regs_pkg::level_t  fifo_level_count_nxt;
  logic                   rst_n, enh_ok, swap, wr_enhanced_mode_select;
  logic [3:0]             msr_delta;

  cfg_byte_if resume_one ();
  cfg_byte_if resume_two ();
  cfg_byte_if pause_one ();
  cfg_byte_if pause_two ();
  cfg_byte_if scratch ();
  cfg_byte_if enhanced_mode_select ();

  // either reset clears the channel; power-up alone touches the divisor
  assign rst_n     = I_RESET_N & I_POWERUP_N;
  assign enh_ok    = efr_r[`EFR_ENH_BIT];
  assign swap      = fctr_r[`FCTR_SWAP_BIT];
  assign modem_now = '{cd: ~I_CD_N, ri: ~I_RI_N, dsr: ~I_DSR_N,
                       cts: ~I_CTS_N};
  assign wr_enhanced_mode_select   = I_WR & ((I_SEL == `SEL_ENHANCED_MODE_SELECT) |
                             ((I_SEL == `SEL_SPR) & swap));

  // flow characters and the two scratch-side bytes
  assign resume_one.load     = I_WR & (I_SEL == `SEL_RESUME_ONE);
  assign resume_two.load     = I_WR & (I_SEL == `SEL_RESUME_TWO);
  assign pause_one.load      = I_WR & (I_SEL == `SEL_PAUSE_ONE);
  assign pause_two.load      = I_WR & (I_SEL == `SEL_PAUSE_TWO);
  assign scratch.load        = I_WR & (I_SEL == `SEL_SPR) & ~swap;
  assign enhanced_mode_select.load           = wr_enhanced_mode_select;
  assign resume_one.value_in = I_WDATA;
  assign resume_two.value_in = I_WDATA;
  assign pause_one.value_in  = I_WDATA;
  assign pause_two.value_in  = I_WDATA;
  assign scratch.value_in    = I_WDATA;
  assign enhanced_mode_select.value_in       = I_WDATA;

  cfg_byte_reg #(.RESET_VAL(`RST_ZERO)) u_resume_one (
    .i_clk (I_CLOCK), .i_rst_n (rst_n), .bus (resume_one.store));
  cfg_byte_reg #(.RESET_VAL(`RST_ZERO)) u_resume_two (
    .i_clk (I_CLOCK), .i_rst_n (rst_n), .bus (resume_two.store));
  cfg_byte_reg #(.RESET_VAL(`RST_ZERO)) u_pause_one (
    .i_clk (I_CLOCK), .i_rst_n (rst_n), .bus (pause_one.store));
  cfg_byte_reg #(.RESET_VAL(`RST_ZERO)) u_pause_two (
    .i_clk (I_CLOCK), .i_rst_n (rst_n), .bus (pause_two.store));
  cfg_byte_reg #(.RESET_VAL(`RST_SPR)) u_scratch (
    .i_clk (I_CLOCK), .i_rst_n (rst_n), .bus (scratch.store));
  cfg_byte_reg #(.RESET_VAL(`RST_ENHANCED_MODE_SELECT)) u_enhanced_mode_select (
    .i_clk (I_CLOCK), .i_rst_n (rst_n), .bus (enhanced_mode_select.store));

  // divisor survives the reset pin, only power-up reloads it
  // writes are held off while the pin is low so the pin never moves it
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_POWERUP_N)
    begin
      div_low_r  <= `RST_DIV_LOW;
      div_high_r <= `RST_DIV_HIGH;
    end
    else if (I_RESET_N && I_WR && I_SEL == `SEL_DIV_LOW)
      div_low_r <= I_WDATA;
    else if (I_RESET_N && I_WR && I_SEL == `SEL_DIV_HIGH)
      div_high_r <= I_WDATA;
  end

  // control bytes; enhanced fields move only while unlocked
  always_ff @(posedge I_CLOCK)
  begin
    if (!rst_n)
    begin
      div_frac_r   <= `RST_ZERO;
      ier_r        <= `RST_ZERO;
      fcr_r        <= `RST_ZERO;
      mcr_r        <= `RST_ZERO;
      lcr_r        <= `RST_ZERO;
      efr_r        <= `RST_ZERO;
      fctr_r       <= `RST_ZERO;
      trig_count_r <= `RST_ZERO;
    end
    else if (I_WR)
    begin
      case (I_SEL)
        `SEL_DIV_FRAC:   if (enh_ok) div_frac_r <= I_WDATA;
        `SEL_IER:        ier_r <= {enh_ok ? I_WDATA[7:4] : ier_r[7:4],
                                   I_WDATA[3:0]};
        `SEL_ISR_FCR:    fcr_r <= {I_WDATA[7:6],
                                   enh_ok ? I_WDATA[5:4] : fcr_r[5:4],
                                   I_WDATA[3:0]};
        `SEL_MCR:        mcr_r <= {enh_ok ? I_WDATA[7:5] : mcr_r[7:5],
                                   I_WDATA[4:0]};
        `SEL_LCR:        lcr_r <= I_WDATA;
        `SEL_EFR:        efr_r <= I_WDATA;
        `SEL_FCTR:       fctr_r <= I_WDATA;
        `SEL_TRIG_COUNT: trig_count_r <= I_WDATA;
        default:         ;
      endcase
    end
  end

  // status bytes follow the datapath once out of reset
  always_ff @(posedge I_CLOCK)
  begin
    if (!rst_n)
    begin
      isr_r <= `RST_ISR;
      lsr_r <= `RST_LSR;
    end
    else
    begin
      isr_r <= {fcr_r[0], fcr_r[0], 2'b00, I_INT_ID};
      lsr_r <= I_LINE_STAT;
    end
  end

  // change bits: a new change wins over a clearing read in the same cycle
  assign msr_delta = {modem_now.cd ^ modem_prev_r.cd,
                      modem_prev_r.ri & ~modem_now.ri,
                      modem_now.dsr ^ modem_prev_r.dsr,
                      modem_now.cts ^ modem_prev_r.cts};

  always_ff @(posedge I_CLOCK)
  begin
    if (!rst_n)
    begin
      msr_r        <= {modem_now, 4'h0};
      modem_prev_r <= modem_now;
    end
    else
    begin
      msr_r[7:4]   <= modem_now;
      msr_r[3:0]   <= msr_delta |
                      ((I_RD && I_SEL == `SEL_MSR) ? 4'h0 : msr_r[3:0]);
      modem_prev_r <= modem_now;
    end
  end

  // read mux; fifo count replaces the scratchpad while swapped
  assign fifo_level_count_nxt = enhanced_mode_select.value_out[`ENHANCED_MODE_SELECT_CNT_TX_BIT] ? I_TX_LEVEL
                                                     : I_RX_LEVEL;

  always_comb
  begin
    case (I_SEL)
      `SEL_IER:        rd_nxt = ier_r;
      `SEL_ISR_FCR:    rd_nxt = isr_r;
      `SEL_LCR:        rd_nxt = lcr_r;
      `SEL_MCR:        rd_nxt = mcr_r;
      `SEL_LSR:        rd_nxt = lsr_r;
      `SEL_MSR:        rd_nxt = msr_r;
      `SEL_SPR:        rd_nxt = swap ? {1'b0, fifo_level_count_nxt}
                                     : scratch.value_out;
      `SEL_DIV_LOW:    rd_nxt = div_low_r;
      `SEL_DIV_HIGH:   rd_nxt = div_high_r;
      `SEL_DIV_FRAC:   rd_nxt = div_frac_r;
      `SEL_EFR:        rd_nxt = efr_r;
      `SEL_RESUME_ONE: rd_nxt = resume_one.value_out;
      `SEL_RESUME_TWO: rd_nxt = resume_two.value_out;
      `SEL_PAUSE_ONE:  rd_nxt = pause_one.value_out;
      `SEL_PAUSE_TWO:  rd_nxt = pause_two.value_out;
      `SEL_FCTR:       rd_nxt = fctr_r;
      `SEL_FIFO_LEVEL_COUNT:       rd_nxt = {1'b0, fifo_level_count_nxt};
      `SEL_TRIG_COUNT: rd_nxt = trig_count_r;
      default:         rd_nxt = `RST_ZERO;
    endcase
  end

  // holding registers live in the datapath, so their select reads zero
  always_ff @(posedge I_CLOCK)
  begin
    if (!rst_n)
      O_RDATA <= `RST_ZERO;
    else if (I_RD)
      O_RDATA <= rd_nxt;
  end

  // pins; int is only driven when op2 gates it, as on legacy parts
  always_ff @(posedge I_CLOCK)
  begin
    if (!rst_n)
    begin
      O_TX      <= 1'b1;
      O_OP2_N   <= 1'b1;
      O_RTS_N   <= 1'b1;
      O_DTR_N   <= 1'b1;
      O_RECEIVE_READY_N_N <= 1'b1;
      O_TRANSMIT_READY_N_N <= 1'b0;
      O_INT     <= 1'b0;
      O_INT_OE  <= 1'b0;
    end
    else
    begin
      O_TX      <= I_TX_SERIAL & ~lcr_r[`LCR_BREAK_BIT];
      O_OP2_N   <= ~mcr_r[`MCR_OP2_BIT];
      O_RTS_N   <= ~mcr_r[`MCR_RTS_BIT];
      O_DTR_N   <= ~mcr_r[`MCR_DTR_BIT];
      O_RECEIVE_READY_N_N <= (I_RX_LEVEL == 7'h00);
      O_TRANSMIT_READY_N_N <= (I_TX_LEVEL == `FIFO_DEPTH);
      O_INT     <= ~isr_r[0];
      O_INT_OE  <= mcr_r[`MCR_OP2_BIT];
    end
  end

  // checks
  default clocking cb @(posedge I_CLOCK); endclocking

  divisor_powerup_a: assert property (
    !I_POWERUP_N |=> div_low_r == 8'h01 && div_high_r == 8'h00)
    else $error("divisor not loaded on power-up");
  divisor_kept_a: assert property (
    I_POWERUP_N && !I_RESET_N |=>
      div_low_r == $past(div_low_r) && div_high_r == $past(div_high_r))
    else $error("reset pin changed the divisor");
  status_reset_a: assert property (
    !rst_n |=> isr_r == 8'h01 && lsr_r == 8'h60 &&
      scratch.value_out == 8'hFF && enhanced_mode_select.value_out == 8'h80)
    else $error("status reset values wrong");
  flow_chars_reset_a: assert property (
    !rst_n |=> (resume_one.value_out | resume_two.value_out |
      pause_one.value_out | pause_two.value_out) == 8'h00)
    else $error("flow characters not cleared");
  modem_reset_a: assert property (
    !rst_n |=> msr_r[3:0] == 4'h0 && msr_r[7:4] == $past(modem_now))
    else $error("modem status reset wrong");
  pins_reset_a: assert property (
    !rst_n |=> O_TX && O_OP2_N && O_RTS_N && O_DTR_N && O_RECEIVE_READY_N_N &&
      !O_TRANSMIT_READY_N_N && !O_INT_OE)
    else $error("pin reset levels wrong");
  enh_lock_a: assert property (disable iff (!rst_n)
    I_WR && I_SEL == `SEL_IER && !enh_ok ##1 rst_n |->
      ier_r[7:4] == $past(ier_r[7:4]))
    else $error("enhanced bits changed while locked");
  swap_read_a: assert property (disable iff (!rst_n)
    I_RD && I_SEL == `SEL_SPR && swap && !enhanced_mode_select.value_out[0] |=>
      O_RDATA == {1'b0, $past(I_RX_LEVEL)})
    else $error("swapped scratch read not fifo count");
  flow_write_a: assert property (disable iff (!rst_n)
    I_WR && I_SEL == `SEL_PAUSE_TWO ##1 rst_n |->
      pause_two.value_out == $past(I_WDATA))
    else $error("flow character write lost");
endmodule
